// [inc/rsu_status_params.svh]
// Purpose: Constants for the reconfiguration status capture block
// Assumes: Included by bare name from the design files
// Notes: Field positions refer to the 32-bit word seen by the shifter
`ifndef RSU_STATUS_PARAMS_SVH
`define RSU_STATUS_PARAMS_SVH
// Current-state word fields
`define MS_MSB 31
`define MS_LSB 30
`define WATCHDOG_ENABLE_BIT_BIT 29
`define BOOT_MSB 23
`define PAD_ZERO 6'h00
// Previous-state word fields
`define CAUSE_MSB 30
`define CAUSE_CRC 29
`define CAUSE_LSB 26
`define PSTATE_MSB 25
`define PSTATE_LSB 24
// Fixed watchdog suffix appended below the 12 user bits
`define WD_SUFFIX 17'h00008
// Boot address of the factory image
`define FACTORY_BOOT 24'h000000
// Improper-capture marker, never a legal one-hot word
`define BAD_CAPTURE 31'h7FFFFFFF
// Capture selection codes
`define SEL_CUR 2'h0
`define SEL_APP2 2'h1
`define SEL_PREV1 2'h2
`define SEL_PREV2 2'h3
// Idle pin levels: done low, active-low pins high
`define PIN_IDLE 4'h7
// Upper limit of the shift clock
`define SHIFT_CLK_MAX_MHZ 40
`endif

// [inc/rsu_status_pkg.sv]
// Purpose: Types for the reconfiguration status capture block
// Assumes: Nothing is imported; users write rsu_status_pkg::name
// Notes: Master state codes are Gray along the load path
package rsu_status_pkg;

  typedef enum logic [1:0] {
    MS_FACTORY = 2'h0,
    MS_APP_LOAD = 2'h1,
    MS_APP_USER = 2'h3,
    MS_RECONFIG = 2'h2
  } master_state_t;

  typedef struct packed {
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_flt;
    logic [3:0] pin_prev;
    logic [2:0] req_sync;
    logic req_seen;
    logic ack_tgl;
    master_state_t ms;
    logic [23:0] boot;
    logic watchdog_enable_bit;
    logic [11:0] wd_msbs;
    logic early_chk;
    logic osc_sel;
    logic app_seen;
    logic reload;
    logic [30:0] prev1;
    logic [30:0] prev2;
    logic [31:0] hold;
  } status_state_t;

  typedef struct packed {
    logic req_tgl;
    logic [1:0] sel;
    logic [2:0] ack_sync;
    logic ack_seen;
    logic busy;
    logic [31:0] sreg;
    logic dout;
  } shift_state_t;

endpackage

// [rtl/remote_upgrade_status_capture.sv]
// Purpose: Records reconfiguration cause and serves status words
// Assumes: Control word inputs hold steady while the request is low
// Notes: sys_clk_i stands for the oscillator or user startup clock
//
// Behaviour
// - Early check: bad image or early done pin reloads factory image.
// - Oscillator option selects internal oscillator for startup.
// - Cause is one of CRC, status error, logic, external reset, watchdog.
// - Current word shows app layout in an app image, factory layout else.
// - Factory word: state, six zero bits, 24-bit boot address.
// - App word one: state, watchdog enable, 29-bit timeout value.
// - App word two: state, six zero bits, running boot address.
// - Two previous-state words: last app image left and the one before it.
// - One-hot cause field, external reset highest, logic request lowest.
// - Simultaneous causes keep only the highest bit position.
// - Previous word keeps master state at the moment of leaving.
// - Previous word keeps boot address of the image it describes.
// - Previous capture before first app entry returns an improper mark.
// - Capture loads the selected status word into the shift register.
// - Shifter on user clock up to 40 MHz; status on own clock.
// - Previous-state words are rewritten on every exit from an app image.
// - Timeout is twelve user bits with the fixed suffix below.
`timescale 1ns/100ps
`include "rsu_status_params.svh"
module remote_upgrade_status_capture (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic error_status_pin_n_i,
  input wire logic external_reconfig_pin_n_i,
  input wire logic logic_reconfig_request_n_i,
  input wire logic load_complete_pin_i,
  input wire logic crc_error_i,
  input wire logic watchdog_timeout_i,
  input wire logic image_valid_i,
  input wire logic load_end_i,
  input wire logic [23:0] boot_addr_i,
  input wire logic watchdog_enable_bit_i,
  input wire logic [11:0] watchdog_timeout_msbs_i,
  input wire logic early_done_check_i,
  input wire logic osc_startup_i,
  input wire logic upgrade_shift_clock_i,
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic [1:0] select_i,
  output logic [1:0] master_state_o,
  output logic factory_reload_o,
  output logic startup_osc_select_o,
  output logic early_check_active_o,
  output logic shift_dout_o,
  output logic capture_busy_o
);

  rsu_status_pkg::status_state_t q;
  rsu_status_pkg::status_state_t n;

  logic [3:0] pins;
  logic err;
  logic ext;
  logic lreq;
  logic done;
  logic lreq_release;
  logic done_rise;
  logic in_load;
  logic in_app;
  logic early_fault;
  logic [4:0] cause_raw;
  logic [4:0] cause;
  logic accept;
  logic req_tgl;
  logic [1:0] req_sel;
  logic [31:0] fac_word;
  logic [31:0] app1_word;
  logic [31:0] sel_word;

  // Highest set bit wins; the rest are dropped
  function automatic logic [4:0] pick_hi(input logic [4:0] v);
    logic [4:0] r;
    r = 5'h00;
    if (v[4])
      r = 5'h10;
    else if (v[3])
      r = 5'h08;
    else if (v[2])
      r = 5'h04;
    else if (v[1])
      r = 5'h02;
    else if (v[0])
      r = 5'h01;
    return r;
  endfunction

  assign pins = {load_complete_pin_i, logic_reconfig_request_n_i,
                 external_reconfig_pin_n_i, error_status_pin_n_i};
  assign err = ~q.pin_flt[0];
  assign ext = ~q.pin_flt[1];
  assign lreq = ~q.pin_flt[2];
  assign done = q.pin_flt[3];
  // Request release starts the load, as the pin goes back high
  assign lreq_release = q.pin_flt[2] & ~q.pin_prev[2];
  assign done_rise = q.pin_flt[3] & ~q.pin_prev[3];
  assign in_load = (q.ms == rsu_status_pkg::MS_APP_LOAD);
  assign in_app = in_load || (q.ms == rsu_status_pkg::MS_APP_USER);

  // Done before the loader finishes counts as a bad image
  assign early_fault = in_load && q.early_chk &&
                       (!image_valid_i || (done_rise && !load_end_i));

  // Watchdog only counts in user mode of an application image
  assign cause_raw = {ext, in_load & (crc_error_i | early_fault),
                      err, q.watchdog_enable_bit & (q.ms == rsu_status_pkg::MS_APP_USER) &
                      watchdog_timeout_i, lreq};
  assign cause = pick_hi(cause_raw);

  // Second and third stages must agree before a request counts
  assign accept = (q.req_sync[1] == q.req_sync[2]) &&
                  (q.req_sync[2] != q.req_seen);

  assign fac_word = {q.ms, `PAD_ZERO, q.boot};
  assign app1_word = {q.ms, q.watchdog_enable_bit, q.wd_msbs, `WD_SUFFIX};

  always_comb
  begin
    case (req_sel)
      `SEL_CUR:
        sel_word = in_app ? app1_word : fac_word;
      `SEL_APP2:
        sel_word = fac_word;
      `SEL_PREV1:
        sel_word = q.app_seen ? {1'b0, q.prev1} :
                   {1'b0, `BAD_CAPTURE};
      default:
        sel_word = q.app_seen ? {1'b0, q.prev2} :
                   {1'b0, `BAD_CAPTURE};
    endcase
  end

  always_comb
  begin
    n = q;
    n.reload = 1'b0;
    n.pin_s1 = pins;
    n.pin_s2 = q.pin_s1;
    n.pin_s3 = q.pin_s2;
    n.pin_prev = q.pin_flt;
    for (int i = 0; i < 4; i++)
    begin
      if (q.pin_s2[i] == q.pin_s3[i])
        n.pin_flt[i] = q.pin_s3[i];
    end
    n.req_sync = {q.req_sync[1:0], req_tgl};
    if (accept)
    begin
      n.req_seen = q.req_sync[2];
      n.hold = sel_word;
      n.ack_tgl = ~q.ack_tgl;
    end
    case (q.ms)
      rsu_status_pkg::MS_FACTORY:
      begin
        if (ext)
          n.ms = rsu_status_pkg::MS_RECONFIG;
        else if (lreq_release)
        begin
          n.ms = rsu_status_pkg::MS_APP_LOAD;
          n.boot = boot_addr_i;
          n.watchdog_enable_bit = watchdog_enable_bit_i;
          n.wd_msbs = watchdog_timeout_msbs_i;
          n.early_chk = early_done_check_i;
          n.osc_sel = osc_startup_i;
          n.app_seen = 1'b1;
        end
      end
      rsu_status_pkg::MS_APP_LOAD,
      rsu_status_pkg::MS_APP_USER:
      begin
        if (|cause)
        begin
          // Every exit from an application image rewrites the history
          n.prev2 = q.prev1;
          n.prev1 = {cause, q.ms, q.boot};
          n.ms = rsu_status_pkg::MS_RECONFIG;
          n.osc_sel = 1'b0;
          n.early_chk = 1'b0;
        end
        else if (in_load && load_end_i && done)
        begin
          n.ms = rsu_status_pkg::MS_APP_USER;
          n.osc_sel = 1'b0;
          n.early_chk = 1'b0;
        end
      end
      rsu_status_pkg::MS_RECONFIG:
      begin
        // Hold off the reload until every trigger pin lets go
        if (!ext && !err && !lreq)
        begin
          n.ms = rsu_status_pkg::MS_FACTORY;
          n.reload = 1'b1;
          n.boot = `FACTORY_BOOT;
          n.watchdog_enable_bit = 1'b0;
        end
      end
      default:
        n.ms = rsu_status_pkg::MS_FACTORY;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q <= '0;
      q.pin_s1 <= `PIN_IDLE;
      q.pin_s2 <= `PIN_IDLE;
      q.pin_s3 <= `PIN_IDLE;
      q.pin_flt <= `PIN_IDLE;
      q.pin_prev <= `PIN_IDLE;
      q.boot <= `FACTORY_BOOT;
    end
    else
    begin
      q <= n;
    end
  end

  status_shift_port u_shift (
    .upgrade_shift_clock_i(upgrade_shift_clock_i),
    .nrst_i(nrst_i),
    .capture_i(capture_i),
    .shift_i(shift_i),
    .select_i(select_i),
    .word_i(q.hold),
    .ack_tgl_i(q.ack_tgl),
    .req_tgl_o(req_tgl),
    .sel_o(req_sel),
    .busy_o(capture_busy_o),
    .dout_o(shift_dout_o)
  );

  assign master_state_o = q.ms;
  assign factory_reload_o = q.reload;
  assign startup_osc_select_o = q.osc_sel;
  assign early_check_active_o = q.early_chk;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_leave;
    in_app && (|cause);
  endsequence

  sequence s_released;
    (q.ms == rsu_status_pkg::MS_RECONFIG) && !ext && !err && !lreq;
  endsequence

  sequence s_start;
    (q.ms == rsu_status_pkg::MS_FACTORY) && !ext && lreq_release;
  endsequence

  AST_EARLY_FAULT: assert property (early_fault |=>
    (q.ms == rsu_status_pkg::MS_RECONFIG) &&
    (|q.prev1[`CAUSE_MSB:`CAUSE_CRC]))
    else $error("early check fault did not abort the load");

  AST_FAULT_RELOAD: assert property (s_released |=>
    q.reload && (q.ms == rsu_status_pkg::MS_FACTORY) &&
    (q.boot == `FACTORY_BOOT) ##1 !q.reload)
    else $error("factory reload not issued once pins released");

  AST_OSC_SELECT: assert property (s_start |=>
    (q.osc_sel == $past(osc_startup_i)) &&
    (q.early_chk == $past(early_done_check_i)) && q.app_seen)
    else $error("startup options not taken at load start");

  AST_CAUSE_ONEHOT: assert property (s_leave |=>
    $onehot(q.prev1[`CAUSE_MSB:`CAUSE_LSB]) &&
    (q.ms == rsu_status_pkg::MS_RECONFIG))
    else $error("previous-state cause is not one-hot");

  AST_CAUSE_PRIORITY: assert property (s_leave ##0 ext |=>
    q.prev1[`CAUSE_MSB:`CAUSE_LSB] == 5'h10)
    else $error("external reset lost priority");

  AST_HISTORY: assert property (s_leave |=>
    (q.prev2 == $past(q.prev1)) &&
    (q.prev1[`PSTATE_MSB:`PSTATE_LSB] == $past(q.ms)) &&
    (q.prev1[`BOOT_MSB:0] == $past(q.boot)))
    else $error("previous-state words not rewritten on exit");

  AST_CUR_LAYOUT: assert property (accept && (req_sel == `SEL_APP2) |=>
    q.hold == {$past(q.ms), `PAD_ZERO, $past(q.boot)})
    else $error("boot address word has wrong layout");

  AST_APP_ONE: assert property (accept && in_app &&
    (req_sel == `SEL_CUR) |=> (q.hold[16:0] == `WD_SUFFIX) &&
    (q.hold[`WATCHDOG_ENABLE_BIT_BIT] == $past(q.watchdog_enable_bit)) &&
    (q.hold[`MS_MSB:`MS_LSB] == $past(q.ms)))
    else $error("application word one has wrong layout");

  AST_IMPROPER: assert property (accept && req_sel[1] && !q.app_seen |=>
    q.hold == {1'b0, `BAD_CAPTURE})
    else $error("early previous-state capture not marked improper");

endmodule

// [rtl/status_shift_port.sv]
// Purpose: Capture and serial shift-out on the upgrade shift clock
// Assumes: capture_i and shift_i come from logic on the same clock
// Notes: Word arrives by toggle handshake; word_i is stable at ack
`timescale 1ns/100ps
module status_shift_port (
  input wire logic upgrade_shift_clock_i,
  input wire logic nrst_i,
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic [1:0] select_i,
  input wire logic [31:0] word_i,
  input wire logic ack_tgl_i,
  output logic req_tgl_o,
  output logic [1:0] sel_o,
  output logic busy_o,
  output logic dout_o
);

  rsu_status_pkg::shift_state_t q;
  rsu_status_pkg::shift_state_t n;
  logic ack_new;

  // Second and third stages must agree before the ack counts
  assign ack_new = (q.ack_sync[1] == q.ack_sync[2]) &&
                   (q.ack_sync[2] != q.ack_seen);

  always_comb
  begin
    n = q;
    n.ack_sync = {q.ack_sync[1:0], ack_tgl_i};
    if (ack_new)
    begin
      n.ack_seen = q.ack_sync[2];
      n.sreg = word_i;
      n.dout = word_i[31];
      n.busy = 1'b0;
    end
    else if (!q.busy && capture_i)
    begin
      n.req_tgl = ~q.req_tgl;
      n.sel = select_i;
      n.busy = 1'b1;
    end
    else if (!q.busy && shift_i)
    begin
      n.sreg = {q.sreg[30:0], 1'b0};
      n.dout = q.sreg[30];
    end
  end

  // Runs on the user shift clock only; may stop between captures
  always_ff @(posedge upgrade_shift_clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q <= '0;
    else
      q <= n;
  end

  assign req_tgl_o = q.req_tgl;
  assign sel_o = q.sel;
  assign busy_o = q.busy;
  assign dout_o = q.dout;

  default clocking cb @(posedge upgrade_shift_clock_i);
  endclocking
  default disable iff (!nrst_i);

  AST_LOAD_WORD: assert property (ack_new |=>
    q.sreg == $past(word_i) && !q.busy && q.dout == $past(word_i[31]))
    else $error("captured word not loaded into shifter");

  AST_SHIFT_MSB: assert property (!q.busy && !ack_new && !capture_i &&
    shift_i |=> q.dout == $past(q.sreg[30]))
    else $error("shift did not present next bit");

  AST_BUSY_HOLD: assert property (!q.busy && !ack_new && capture_i |=>
    q.busy [*3])
    else $error("capture finished faster than the crossing allows");

endmodule

// [tb/remote_upgrade_status_capture_test.sv]
// Purpose: Self-checking bench for the status capture block
// Assumes: Pin changes need a few system cycles to pass the filters
// Notes: Every reconfiguration cause is walked once from a small table
`timescale 1ns/100ps
module remote_upgrade_status_capture_test;
  logic sys_clk_i = 1'b0;
  logic upgrade_shift_clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic error_status_pin_n_i = 1'b1, external_reconfig_pin_n_i = 1'b1;
  logic logic_reconfig_request_n_i = 1'b1, load_complete_pin_i = 1'b0;
  logic crc_error_i = 1'b0, watchdog_timeout_i = 1'b0, load_end_i = 1'b0;
  logic image_valid_i = 1'b1, watchdog_enable_bit_i = 1'b1;
  logic early_done_check_i = 1'b1, osc_startup_i = 1'b1;
  logic [23:0] boot_addr_i = 24'h000000;
  logic [11:0] watchdog_timeout_msbs_i = 12'hABC;
  logic capture_i, shift_i, capture_busy_o, shift_dout_o;
  logic [1:0] select_i, master_state_o;
  logic factory_reload_o, startup_osc_select_o, early_check_active_o;
  logic [31:0] last_prev = 32'h00000000;
  int n_fail = 0;
  int checks_done = 0;

  always #2 sys_clk_i = ~sys_clk_i;
  // 30 ns shift clock keeps well below the shifter's upper limit
  always #15 upgrade_shift_clock_i = ~upgrade_shift_clock_i;

  remote_upgrade_status_capture dut_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .error_status_pin_n_i(error_status_pin_n_i),
    .external_reconfig_pin_n_i(external_reconfig_pin_n_i),
    .logic_reconfig_request_n_i(logic_reconfig_request_n_i),
    .load_complete_pin_i(load_complete_pin_i), .crc_error_i(crc_error_i),
    .watchdog_timeout_i(watchdog_timeout_i), .image_valid_i(image_valid_i),
    .load_end_i(load_end_i), .boot_addr_i(boot_addr_i),
    .watchdog_enable_bit_i(watchdog_enable_bit_i),
    .watchdog_timeout_msbs_i(watchdog_timeout_msbs_i),
    .early_done_check_i(early_done_check_i), .osc_startup_i(osc_startup_i),
    .upgrade_shift_clock_i(upgrade_shift_clock_i), .capture_i(capture_i),
    .shift_i(shift_i), .select_i(select_i),
    .master_state_o(master_state_o), .factory_reload_o(factory_reload_o),
    .startup_osc_select_o(startup_osc_select_o),
    .early_check_active_o(early_check_active_o),
    .shift_dout_o(shift_dout_o), .capture_busy_o(capture_busy_o)
  );

  status_reader reader_u (
    .upgrade_shift_clock_i(upgrade_shift_clock_i),
    .capture_busy_i(capture_busy_o), .shift_dout_i(shift_dout_o),
    .capture_o(capture_i), .shift_o(shift_i), .select_o(select_i)
  );

  task automatic end_of_test;
    begin
      if (n_fail == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic tick(input int n);
    begin
      repeat (n) @(posedge sys_clk_i);
      #1;
    end
  endtask

  task automatic wait_state(input logic [1:0] st);
    int n;
    begin
      n = 0;
      while (master_state_o !== st && n < 100)
      begin
        tick(1);
        n++;
      end
      check({30'h0, master_state_o}, {30'h0, st});
    end
  endtask

  task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
    logic [31:0] w;
    logic ok;
    begin
      reader_u.read_word(sel, w, ok);
      check({31'h0, ok}, 32'h1);
      check(w, exp);
      tick(1);
    end
  endtask

  task automatic reset_check;
    begin
      check({27'h0, master_state_o, factory_reload_o, startup_osc_select_o,
        early_check_active_o}, 32'h0);
      rd(2'h0, 32'h00000000);
      rd(2'h2, 32'h7FFFFFFF);
      rd(2'h3, 32'h7FFFFFFF);
    end
  endtask

  // k: 0 ext+logic together, 1 crc, 2 status, 3 watchdog, 4 logic,
  // 5 early done, 6 invalid image
  task automatic run_cause(input int k);
    logic [23:0] boot;
    logic [4:0] cause;
    logic [1:0] st;
    begin
      boot = 24'h100000 + 24'(k) * 24'h010400;
      cause = (k == 0) ? 5'h10 : (k == 1 || k > 4) ? 5'h08 : 5'h10 >> k;
      st = (k == 1 || k > 4) ? 2'h1 : 2'h3;
      image_valid_i = (k != 6);
      boot_addr_i = boot;
      logic_reconfig_request_n_i = 1'b0;
      tick(10);
      logic_reconfig_request_n_i = 1'b1;
      if (k != 6)
      begin
        wait_state(rsu_status_pkg::MS_APP_LOAD);
        check({30'h0, startup_osc_select_o, early_check_active_o},
          32'h3);
      end
      if (k == 0 || (k > 1 && k < 5))
      begin
        load_end_i = 1'b1;
        load_complete_pin_i = 1'b1;
        wait_state(rsu_status_pkg::MS_APP_USER);
        load_end_i = 1'b0;
      end
      if (k == 0)
      begin
        rd(2'h0, {2'h3, 1'b1, 12'hABC, 17'h00008});
        rd(2'h1, {2'h3, 6'h00, boot});
      end
      // Done rising without the loader's end mark is the early fault
      if (k == 5)
        load_complete_pin_i = 1'b1;
      crc_error_i = (k == 1);
      error_status_pin_n_i = (k != 2);
      watchdog_timeout_i = (k == 3);
      external_reconfig_pin_n_i = (k != 0);
      logic_reconfig_request_n_i = (k != 0 && k != 4);
      wait_state(rsu_status_pkg::MS_RECONFIG);
      crc_error_i = 1'b0;
      watchdog_timeout_i = 1'b0;
      load_complete_pin_i = 1'b0;
      error_status_pin_n_i = 1'b1;
      external_reconfig_pin_n_i = 1'b1;
      logic_reconfig_request_n_i = 1'b1;
      image_valid_i = 1'b1;
      wait_state(rsu_status_pkg::MS_FACTORY);
      check({31'h0, factory_reload_o}, 32'h1);
      tick(1);
      check({31'h0, factory_reload_o}, 32'h0);
      rd(2'h2, {1'b0, cause, st, boot});
      rd(2'h3, last_prev);
      rd(2'h0, 32'h00000000);
      last_prev = {1'b0, cause, st, boot};
    end
  endtask

  // Causes the design must ignore, and an image with its watchdog off
  task automatic run_refused;
    logic [23:0] boot;
    begin
      boot = 24'h2A0000;
      boot_addr_i = boot;
      external_reconfig_pin_n_i = 1'b0;
      wait_state(rsu_status_pkg::MS_RECONFIG);
      external_reconfig_pin_n_i = 1'b1;
      wait_state(rsu_status_pkg::MS_FACTORY);
      tick(2);
      rd(2'h2, last_prev);
      watchdog_enable_bit_i = 1'b0;
      logic_reconfig_request_n_i = 1'b0;
      tick(10);
      logic_reconfig_request_n_i = 1'b1;
      wait_state(rsu_status_pkg::MS_APP_LOAD);
      load_end_i = 1'b1;
      load_complete_pin_i = 1'b1;
      wait_state(rsu_status_pkg::MS_APP_USER);
      load_end_i = 1'b0;
      // CRC only counts during load; a disabled watchdog never fires
      crc_error_i = 1'b1;
      watchdog_timeout_i = 1'b1;
      tick(8);
      check({30'h0, master_state_o}, 32'h3);
      rd(2'h0, {2'h3, 1'b0, 12'hABC, 17'h00008});
      crc_error_i = 1'b0;
      watchdog_timeout_i = 1'b0;
      logic_reconfig_request_n_i = 1'b0;
      wait_state(rsu_status_pkg::MS_RECONFIG);
      logic_reconfig_request_n_i = 1'b1;
      load_complete_pin_i = 1'b0;
      wait_state(rsu_status_pkg::MS_FACTORY);
      rd(2'h2, {1'b0, 5'h01, 2'h3, boot});
      rd(2'h3, last_prev);
      watchdog_enable_bit_i = 1'b1;
    end
  endtask

  initial
  begin
    // Reset spans two shift-clock edges so both domains see it
    repeat (2) @(posedge upgrade_shift_clock_i);
    @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    tick(2);
    reset_check();
    for (int k = 0; k < 7; k++)
      run_cause(k);
    run_refused();
    end_of_test();
  end

  // Whole run needs about 34 us; the limit leaves over three times that
  initial
  begin
    #120000;
    n_fail++;
    end_of_test();
  end
endmodule

// [tb/status_reader.sv]
// Purpose: Logic-array reader of the status shift port
// Assumes: Runs on the upgrade shift clock and drives its inputs after #1
// Notes: Select is held until the next read, so it stays steady while busy
`timescale 1ns/100ps
module status_reader (
  input wire logic upgrade_shift_clock_i,
  input wire logic capture_busy_i,
  input wire logic shift_dout_i,
  output logic capture_o,
  output logic shift_o,
  output logic [1:0] select_o
);
  initial
  begin
    capture_o = 1'b0;
    shift_o = 1'b0;
    select_o = 2'h0;
  end

  // Capture one word, wait for the load, then clock it out MSB first
  task automatic read_word(input logic [1:0] sel, output logic [31:0] w,
    output logic ok);
    int n;
    begin
      n = 0;
      @(posedge upgrade_shift_clock_i);
      #1;
      select_o = sel;
      capture_o = 1'b1;
      @(posedge upgrade_shift_clock_i);
      #1;
      capture_o = 1'b0;
      while (capture_busy_i !== 1'b0 && n < 60)
      begin
        @(posedge upgrade_shift_clock_i);
        #1;
        n++;
      end
      ok = (n < 60);
      w[31] = shift_dout_i;
      shift_o = 1'b1;
      for (int i = 30; i >= 0; i--)
      begin
        @(posedge upgrade_shift_clock_i);
        #1;
        w[i] = shift_dout_i;
      end
      shift_o = 1'b0;
    end
  endtask
endmodule
